//--- rtl/fpo_pkg.sv
// Constants shared by the four-point output port and its delay timer.
// Assumes a 250 MHz clock and a classic Wishbone slave with 32-bit data.
`default_nettype none
package fpo_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 250000000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  // Host silence that counts as link loss
  localparam int unsigned LINK_LOSS_MS   = 500;
  localparam int unsigned LINK_LOSS_TICKS = LINK_LOSS_MS / TICK_MS;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OUT_OFS     = 8'h00;
  localparam logic [7:0] POINT_OFS   = 8'h04;
  localparam logic [7:0] KIND_OFS    = 8'h08;
  localparam logic [7:0] PATTERN_OFS = 8'h0c;
  localparam logic [7:0] DELAY_OFS   = 8'h10;
  localparam logic [7:0] COMMIT_OFS  = 8'h14;
  localparam logic [7:0] STATUS_OFS  = 8'h18;
  localparam logic [7:0] ACTIVE_OFS  = 8'h1c;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int unsigned NPOINTS     = 4;
  localparam int unsigned POINT_IDX_LSB = 0;
  localparam int unsigned POINT_VAL_BIT = 8;
  localparam logic [3:0] OUT_RST      = 4'h0;
  localparam logic [3:0] PATTERN_RST  = 4'h0;
  localparam logic [7:0] DELAY_RST    = 8'h00;

  typedef enum logic [1:0] {
    FPO_KIND_NONE = 2'b00,
    FPO_KIND_OFF  = 2'b01,
    FPO_KIND_PAT  = 2'b10,
    FPO_KIND_HOLD = 2'b11
  } fpo_kind_t;

  localparam fpo_kind_t KIND_RST = FPO_KIND_OFF;
endpackage : fpo_pkg
`default_nettype wire

//--- rtl/fpo_timer.sv
// Fail-safe supervisor timer: tenth-second ticks, link-loss and delay counting.
// Assumes activity_i pulses on each valid host transaction.
`default_nettype none
module fpo_timer
  import fpo_pkg::*;
#(
  // Clock cycles per tenth of a second
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       activity_i,
  input  wire logic [7:0] delay_i,
  // Status
  output logic            lost_o,
  output logic            engage_o
);
  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  logic [27:0] pre_reg, pre_next;
  logic [7:0]  loss_reg, loss_next;
  logic [7:0]  dly_reg, dly_next;
  logic        lost_reg, lost_next;
  logic        eng_reg, eng_next;
  logic        tick;

  assign tick = (pre_reg == 28'(TICK_LEN - 1));

  always_comb begin
    pre_next  = tick ? 28'h0 : pre_reg + 28'h1;
    loss_next = loss_reg;
    dly_next  = dly_reg;
    lost_next = lost_reg;
    eng_next  = eng_reg;
    if (activity_i) begin
      // Any transaction restarts both counts and releases the outputs
      pre_next  = 28'h0;
      loss_next = 8'h00;
      dly_next  = 8'h00;
      lost_next = 1'b0;
      eng_next  = 1'b0;
    end else if (!lost_reg) begin
      if (tick) begin
        loss_next = loss_reg + 8'h1;
      end
      if (tick && loss_reg == 8'(LINK_LOSS_TICKS - 1)) begin
        lost_next = 1'b1;
        eng_next  = (delay_i == 8'h00);
      end
    end else if (!eng_reg) begin
      if (dly_reg >= delay_i) begin
        eng_next = 1'b1;
      end else if (tick) begin
        dly_next = dly_reg + 8'h1;
        eng_next = (dly_reg + 8'h1) >= delay_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg  <= 28'h0;
      loss_reg <= 8'h00;
      dly_reg  <= 8'h00;
      lost_reg <= 1'b0;
      eng_reg  <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      loss_reg <= loss_next;
      dly_reg  <= dly_next;
      lost_reg <= lost_next;
      eng_reg  <= eng_next;
    end
  end

  assign lost_o   = lost_reg;
  assign engage_o = eng_reg;
endmodule : fpo_timer
`default_nettype wire

//--- rtl/fpo_port.sv
// Four-point output port with fail-safe supervisor, classic Wishbone slave.
// Assumes one synchronous clock; only mapped Wishbone accesses count as host traffic.
// Operation
// - Four on/off points 0..3, each settable and readable by the host.
// - Packed writes keep bits 3:0 only; higher bits are discarded.
// - Lost host communication drives the points into fail-safe.
// - Kind 1 forces off, 2 drives pattern, 3 holds last state.
// - Pattern mode only for kind 2: one bit on, zero bit off.
// - Fail-safe delay counts in tenths of a second.
// - Delay zero engages at once; maximum 255 gives 25.5 seconds.
// - Written kind, pattern and delay are only staged.
// - Commit copies staged values to active, then clears itself.
`default_nettype none
module fpo_port
  import fpo_pkg::*;
#(
  // Clock cycles per tenth of a second; a bench may shorten it to reach fail-safe
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Output points
  output logic [3:0]       points_o,
  output logic             failsafe_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0]  host_reg, host_next;
  logic [3:0]  pts_reg, pts_next;
  // Staged copies, written by the host
  fpo_kind_t   stg_kind_reg, stg_kind_next;
  logic [3:0]  stg_pat_reg, stg_pat_next;
  logic [7:0]  stg_dly_reg, stg_dly_next;
  // Active copies, used by the supervisor
  fpo_kind_t   failsafe_kind_reg, failsafe_kind_next;
  logic [3:0]  failsafe_pattern_reg, failsafe_pattern_next;
  logic [7:0]  failsafe_delay_reg, failsafe_delay_next;
  logic        failsafe_commit_reg, failsafe_commit_next;
  logic [3:0]  hold_reg, hold_next;
  logic        eng_d_reg, eng_d_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        ack_reg, ack_next;
  logic        err_reg, err_next;
  logic        req, wr, lost, engage, mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OUT_OFS    || a == POINT_OFS   ||
           a == KIND_OFS   || a == PATTERN_OFS ||
           a == DELAY_OFS  || a == COMMIT_OFS  ||
           a == STATUS_OFS || a == ACTIVE_OFS;
  endfunction : is_mapped

  // A registered answer blocks a second take of the same request
  assign req    = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign wr     = req && wb_we_i && wb_sel_i[0] && mapped;
  assign mapped = is_mapped(wb_adr_i);

  // ---------------------------------------------------------------
  // Supervisor timer
  // ---------------------------------------------------------------
  // Only mapped accesses count as host traffic; a stray address does not hold it off
  fpo_timer #(
    .TICK_LEN (TICK_LEN)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .activity_i (req && mapped),
    .delay_i    (failsafe_delay_reg),
    .lost_o     (lost),
    .engage_o   (engage)
  );

  // ---------------------------------------------------------------
  // Register writes and commit
  // ---------------------------------------------------------------
  always_comb begin
    host_next             = host_reg;
    stg_kind_next         = stg_kind_reg;
    stg_pat_next          = stg_pat_reg;
    stg_dly_next          = stg_dly_reg;
    failsafe_kind_next    = failsafe_kind_reg;
    failsafe_pattern_next = failsafe_pattern_reg;
    failsafe_delay_next   = failsafe_delay_reg;
    failsafe_commit_next  = 1'b0;
    // Commit lands the cycle after its write; the bus cannot take a write then
    if (failsafe_commit_reg) begin
      failsafe_kind_next    = stg_kind_reg;
      failsafe_pattern_next = stg_pat_reg;
      failsafe_delay_next   = stg_dly_reg;
    end
    if (wr) begin
      unique case (wb_adr_i)
        OUT_OFS:     host_next = wb_dat_i[3:0];
        POINT_OFS:   host_next[wb_dat_i[POINT_IDX_LSB +: 2]] = wb_dat_i[POINT_VAL_BIT];
        KIND_OFS:    stg_kind_next = fpo_kind_t'(wb_dat_i[1:0]);
        PATTERN_OFS: stg_pat_next = wb_dat_i[3:0];
        DELAY_OFS:   stg_dly_next = wb_dat_i[7:0];
        COMMIT_OFS:  failsafe_commit_next = wb_dat_i[0];
        default:     ;
      endcase
    end
  end

  // Staged and active copies reset alike, so a lone commit changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_reg             <= OUT_RST;
      stg_kind_reg         <= KIND_RST;
      stg_pat_reg          <= PATTERN_RST;
      stg_dly_reg          <= DELAY_RST;
      failsafe_kind_reg    <= KIND_RST;
      failsafe_pattern_reg <= PATTERN_RST;
      failsafe_delay_reg   <= DELAY_RST;
      failsafe_commit_reg  <= 1'b0;
    end else begin
      host_reg             <= host_next;
      stg_kind_reg         <= stg_kind_next;
      stg_pat_reg          <= stg_pat_next;
      stg_dly_reg          <= stg_dly_next;
      failsafe_kind_reg    <= failsafe_kind_next;
      failsafe_pattern_reg <= failsafe_pattern_next;
      failsafe_delay_reg   <= failsafe_delay_next;
      failsafe_commit_reg  <= failsafe_commit_next;
    end
  end

  // ---------------------------------------------------------------
  // Output selection
  // ---------------------------------------------------------------
  // Points lag host_reg by one cycle; fail-safe values enter on the same edge
  always_comb begin
    // Hold keeps the points sampled in the cycle before engagement
    hold_next  = engage ? hold_reg : pts_reg;
    eng_d_next = engage;
    pts_next   = host_reg;
    if (engage) begin
      unique case (failsafe_kind_reg)
        FPO_KIND_OFF:  pts_next = 4'h0;
        FPO_KIND_PAT:  pts_next = failsafe_pattern_reg;
        FPO_KIND_HOLD: pts_next = eng_d_reg ? hold_reg : pts_reg;
        // Undefined kind falls to the safe level
        FPO_KIND_NONE: pts_next = 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pts_reg   <= OUT_RST;
      hold_reg  <= OUT_RST;
      eng_d_reg <= 1'b0;
    end else begin
      pts_reg   <= pts_next;
      hold_reg  <= hold_next;
      eng_d_reg <= eng_d_next;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  // Every access takes two cycles; the master need not drop cyc in between
  always_comb begin
    ack_next  = req && mapped;
    err_next  = req && !mapped;
    rdat_next = 32'h0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        OUT_OFS:     rdat_next = {28'h0, host_reg};
        // Point read shows the driven points, fail-safe included
        POINT_OFS:   rdat_next = {28'h0, pts_reg};
        KIND_OFS:    rdat_next = {30'h0, stg_kind_reg};
        PATTERN_OFS: rdat_next = {28'h0, stg_pat_reg};
        DELAY_OFS:   rdat_next = {24'h0, stg_dly_reg};
        STATUS_OFS:  rdat_next = {30'h0, engage, lost};
        ACTIVE_OFS:  rdat_next = {16'h0, failsafe_delay_reg, failsafe_pattern_reg,
                                  2'h0, failsafe_kind_reg};
        // Commit reads back as zero: it never stays set
        default:     rdat_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0;
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      rdat_reg <= rdat_next;
      ack_reg  <= ack_next;
      err_reg  <= err_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // failsafe_o and points_o come from one edge, so they switch together
  assign wb_dat_o   = rdat_reg;
  assign wb_ack_o   = ack_reg;
  assign wb_err_o   = err_reg;
  assign points_o   = pts_reg;
  assign failsafe_o = eng_d_reg;
endmodule : fpo_port
`default_nettype wire

//--- dv/fpo_port_asserts.sv
// Checker for the four-point output port: bus answers and fail-safe outputs.
// Sees only the top module's ports; attached by the bind at the foot.
`default_nettype none
module fpo_port_asserts
  import fpo_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [3:0]  points_o,
  input wire logic        failsafe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------
  // Mirror of the active kind and pattern
  // --------------------------------------------
  logic [1:0] kind_stg_reg, kind_act_reg;
  logic [3:0] pat_stg_reg, pat_act_reg;
  logic       taken, wr_ok, bad_adr, fs2;
  assign taken   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_ok   = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign bad_adr = wb_adr_i[1:0] != 2'b00 || wb_adr_i > ACTIVE_OFS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_stg_reg <= FPO_KIND_OFF;
      kind_act_reg <= FPO_KIND_OFF;
      pat_stg_reg  <= 4'h0;
      pat_act_reg  <= 4'h0;
      fs2          <= 1'b0;
    end else begin
      fs2 <= failsafe_o;
      if (wr_ok && wb_adr_i == KIND_OFS) kind_stg_reg <= wb_dat_i[1:0];
      if (wr_ok && wb_adr_i == PATTERN_OFS) pat_stg_reg <= wb_dat_i[3:0];
      if (wr_ok && wb_adr_i == COMMIT_OFS && wb_dat_i[0]) begin
        kind_act_reg <= kind_stg_reg;
        pat_act_reg  <= pat_stg_reg;
      end
    end
  end
  sequence s_out_wr; wr_ok && wb_adr_i == OUT_OFS; endsequence
  sequence s_held; failsafe_o && fs2; endsequence
  property p_answer; taken |=> (wb_ack_o || wb_err_o) && wb_err_o == $past(bad_adr); endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o && !wb_err_o; endproperty
  property p_out; s_out_wr |=> points_o == $past(wb_dat_i[3:0]); endproperty
  property p_point_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == POINT_OFS |-> wb_dat_o[3:0] == $past(points_o);
  endproperty
  property p_fs_enter; $rose(failsafe_o) |-> !$past(wb_ack_o) && !$past(wb_err_o); endproperty
  property p_fs_off; s_held and kind_act_reg[1] == 1'b0 |-> points_o == 4'h0; endproperty
  property p_fs_pat; s_held and kind_act_reg == FPO_KIND_PAT |-> points_o == pat_act_reg; endproperty
  property p_fs_hold; s_held and kind_act_reg == FPO_KIND_HOLD |-> $stable(points_o); endproperty
  property p_resume; wb_ack_o |-> ##[1:3] !failsafe_o; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered as mapped");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_out: assert property (p_out)
    else $error("points differ from packed write");
  a_point_rd: assert property (p_point_rd)
    else $error("point read differs from outputs");
  a_fs_enter: assert property (p_fs_enter)
    else $error("fail-safe entered during traffic");
  a_fs_off: assert property (p_fs_off)
    else $error("off kind left points on");
  a_fs_pat: assert property (p_fs_pat)
    else $error("points differ from pattern");
  a_fs_hold: assert property (p_fs_hold)
    else $error("hold kind changed points");
  a_resume: assert property (p_resume)
    else $error("fail-safe kept after host access");
endmodule : fpo_port_asserts
bind fpo_port fpo_port_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .points_o(points_o), .failsafe_o(failsafe_o)
);
`default_nettype wire

//--- dv/fpo_host.sv
// Host model: a classic Wishbone master issuing single cycles.
// Assumes only the bench's main sequence calls xfer.
`default_nettype none
module fpo_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, sel_o} = '0;
    adr_o = 8'hff;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    // Waits as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (!(ack_i || err_i));
    q = dat_i;
    e = err_i;
    // Released address and data show the inverse so stale values never pass
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
  endtask : xfer
endmodule : fpo_host
`default_nettype wire

//--- dv/fpo_port_test.sv
// Self-checking bench for the four-point output port.
// Assumes fpo_host drives the bus; a short tick brings fail-safe into the run.
`default_nettype none
module fpo_port_test
  import fpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, x) begin compares++; if ((g) !== (x)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [15:0] ex;} fpo_row_t;
  localparam int unsigned FS_TICK = 8;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, err, fs, e;
  logic [7:0]  adr;
  logic [3:0]  sel, pts;
  logic [31:0] dw, dr, q;
  int          bad_count = 0, compares = 0;
  fpo_row_t    rows [11] = '{
    '{OUT_OFS, 32'h5a, OUT_OFS, 16'h000a}, '{OUT_OFS, 32'hffffffff, POINT_OFS, 16'h000f},
    '{POINT_OFS, 32'h000, POINT_OFS, 16'h000e}, '{OUT_OFS, 32'h10, OUT_OFS, 16'h0000},
    '{POINT_OFS, 32'h102, POINT_OFS, 16'h0004}, '{KIND_OFS, 32'h102, KIND_OFS, 16'h0002},
    '{PATTERN_OFS, 32'h35, PATTERN_OFS, 16'h0005}, '{DELAY_OFS, 32'h1ff, ACTIVE_OFS, 16'h0001},
    '{COMMIT_OFS, 32'h0, ACTIVE_OFS, 16'h0001}, '{COMMIT_OFS, 32'h1, ACTIVE_OFS, 16'hff52},
    '{COMMIT_OFS, 32'h1, COMMIT_OFS, 16'h0000}};
  always #2 clk_i = ~clk_i;
  fpo_port #(.TICK_LEN(FS_TICK)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .wb_err_o(err), .points_o(pts), .failsafe_o(fs));
  fpo_host host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(dr), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hf, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, 4'hf, q, e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic test_done;
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(pts, 4'h0)
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      `CHK(q[15:0], rows[i].ex)
    end
    // Kinds 1 to 3, staged first and then committed
    for (int k = 1; k < 4; k++) begin
      wr(KIND_OFS, 32'(k));
      wr(DELAY_OFS, 32'(k * 127));
      wr(COMMIT_OFS, 32'h1);
      rd(ACTIVE_OFS);
      `CHK(q[15:0], {8'(k * 127), 4'h5, 2'b00, 2'(k)})
    end
    host.xfer(1'b1, 8'h20, 32'h0, 4'hf, q, e);
    `CHK(e, 1'b1)
    host.xfer(1'b1, OUT_OFS, 32'hf, 4'he, q, e);
    rd(POINT_OFS);
    `CHK(q[3:0], 4'h4)
    `CHK(fs, 1'b0)
    // Silence: pattern kind with a two-tick delay, then resume
    wr(OUT_OFS, 32'h9);
    wr(KIND_OFS, 32'h2);
    wr(PATTERN_OFS, 32'h16);
    wr(DELAY_OFS, 32'h2);
    wr(COMMIT_OFS, 32'h1);
    idle((LINK_LOSS_TICKS + 2) * FS_TICK - 4);
    `CHK(fs, 1'b0)
    `CHK(pts, 4'h9)
    idle(6);
    `CHK(fs, 1'b1)
    `CHK(pts, 4'h6)
    rd(STATUS_OFS);
    `CHK(q[1:0], 2'b11)
    @(posedge clk_i);
    `CHK(pts, 4'h9)
    `CHK(fs, 1'b0)
    // Off kind with no delay
    wr(KIND_OFS, 32'h1);
    wr(DELAY_OFS, 32'h0);
    wr(COMMIT_OFS, 32'h1);
    idle(LINK_LOSS_TICKS * FS_TICK - 4);
    `CHK(fs, 1'b0)
    idle(6);
    `CHK(fs, 1'b1)
    `CHK(pts, 4'h0)
    // Hold kind; a later kind write stays staged only
    wr(OUT_OFS, 32'h3);
    wr(KIND_OFS, 32'h3);
    wr(DELAY_OFS, 32'h1);
    wr(COMMIT_OFS, 32'h1);
    wr(KIND_OFS, 32'h2);
    idle((LINK_LOSS_TICKS + 1) * FS_TICK - 4);
    `CHK(fs, 1'b0)
    idle(6);
    `CHK(fs, 1'b1)
    `CHK(pts, 4'h3)
    idle(FS_TICK);
    `CHK(pts, 4'h3)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ACTIVE_OFS);
    `CHK(q[15:0], 16'h0001)
    rd(KIND_OFS);
    `CHK(q[15:0], 16'h0001)
    `CHK(pts, 4'h0)
    `CHK(fs, 1'b0)
    test_done();
  end
endmodule : fpo_port_test
`default_nettype wire
